// >>> hdl/ptccc_top.sv
// Purpose: Six-channel counter clock and clear control with Wishbone access
// Assumes: Counters, compare and capture logic live outside this block
// Notes: Pins pass two flip-flops before use
//
// Added by the designer: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
module ptccc_top
  import ptccc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic standby_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // External clock pins A..D
  input wire logic [3:0] ext_clk_i,
  // Wrap strobes of counters
  input wire logic [5:0] wrap_i,
  // Compare or capture events
  input wire ptccc_match_s [5:0] match_i,
  // Counter clears from other channels
  input wire logic [5:0] sync_clear_i,
  // Strobes to counters
  output logic [5:0] count_o,
  output logic [5:0] clear_o
);
  logic [7:0] ctrl_reg [PTCCC_NCH]; // Control registers
  logic [5:0] sync_reg; // Sync enables
  logic [3:0] bufcd4_reg; // C,D buffer flags ch0 [1:0], ch3 [3:2]
  logic [5:0] phase_reg; // Phase counting flags
  logic [3:0] ext_s1_reg; // First sync stage
  logic [3:0] ext_s2_reg; // Second sync stage
  logic [PTCCC_PRE_BITS-1:0] pre_reg; // Prescaler
  logic [PTCCC_PRE_BITS-1:0] pre_next;
  logic [6:0] taps; // Division taps
  logic req; // Wishbone request
  logic wr; // Write strobe
  logic [7:0] wdata; // Low lane data
  logic [31:0] rdata;
  logic [5:0] sync_any;

  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i & sel_i[0];
  assign wdata = dat_i[7:0];

  // ==========================================================
  // Pin synchroniser
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ext_s1_reg <= 4'h0;
      ext_s2_reg <= 4'h0;
    end
    else
    begin
      ext_s1_reg <= ext_clk_i;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  // ==========================================================
  // Free-running prescaler
  assign pre_next = pre_reg + 12'h001;
  always_ff @(posedge clk_i)
  begin
    if (rst_i) pre_reg <= 12'h000;
    else pre_reg <= pre_next;
  end
  // Tap 0 is a strobe each cycle; others square waves
  assign taps[0] = 1'b1;
  assign taps[1] = pre_reg[1];
  assign taps[2] = pre_reg[3];
  assign taps[3] = pre_reg[5];
  assign taps[4] = pre_reg[7];
  assign taps[5] = pre_reg[9];
  assign taps[6] = pre_reg[11];

  // ==========================================================
  // Wishbone acknowledge, one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i) ack_o <= 1'b0;
    else ack_o <= req;
  end

  // ==========================================================
  // Control registers, forced to zero by reset and standby
  genvar g;
  generate
    for (g = 0; g < PTCCC_NCH; g++)
    begin : g_ctrl
      localparam logic [7:0] MASK =
        ((g == 0) || (g == 3)) ? 8'hFF : PTCCC_NARROW_MASK;
      always_ff @(posedge clk_i)
      begin
        if (rst_i || standby_i) ctrl_reg[g] <= PTCCC_CTRL_RST;
        else if (wr && adr_i == PTCCC_CTRL_BASE + 8'(4 * g))
          ctrl_reg[g] <= wdata & MASK;
      end
    end
  endgenerate

  // Sync, buffer and phase configuration
  always_ff @(posedge clk_i)
  begin
    if (rst_i || standby_i)
    begin
      sync_reg <= PTCCC_SYNC_RST;
      bufcd4_reg <= 4'h0;
      phase_reg <= 6'h00;
    end
    else if (wr)
    begin
      if (adr_i == PTCCC_SYNC_OFF) sync_reg <= wdata[5:0];
      if (adr_i == PTCCC_BUFCD_OFF) bufcd4_reg <= wdata[3:0];
      if (adr_i == PTCCC_PHASE_OFF) phase_reg <= wdata[5:0] & 6'h36;
    end
  end

  // ==========================================================
  // Read multiplexer, unmapped reads give zero
  always_comb
  begin
    rdata = 32'h0000_0000;
    for (int i = 0; i < PTCCC_NCH; i++)
      if (adr_i == PTCCC_CTRL_BASE + 8'(4 * i))
        rdata = {24'h000000, ctrl_reg[i]};
    if (adr_i == PTCCC_SYNC_OFF) rdata = {26'h0, sync_reg};
    if (adr_i == PTCCC_BUFCD_OFF) rdata = {28'h0, bufcd4_reg};
    if (adr_i == PTCCC_PHASE_OFF) rdata = {26'h0, phase_reg};
  end

  // Read data register
  always_ff @(posedge clk_i)
  begin
    if (rst_i) dat_o <= 32'h0000_0000;
    else if (req && !we_i) dat_o <= rdata;
  end

  // ==========================================================
  // Synchronous clear from any other enabled channel
  generate
    for (g = 0; g < PTCCC_NCH; g++)
    begin : g_chan
      localparam int CASC = (g == 1) ? 2 : 5;
      assign sync_any[g] =
        |(sync_clear_i & sync_reg & ~(6'h01 << g));
      ptccc_chan #(.CH(g)) u_ptccc_chan (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ctrl_i(ctrl_reg[g]),
        .sync_en_i(sync_reg[g]),
        .buf_c_i((g == 0) ? bufcd4_reg[0] :
          ((g == 3) ? bufcd4_reg[2] : 1'b0)),
        .buf_d_i((g == 0) ? bufcd4_reg[1] :
          ((g == 3) ? bufcd4_reg[3] : 1'b0)),
        .phase_i(phase_reg[g]),
        .tap_i(taps),
        .ext_i(ext_s2_reg),
        .cascade_i(wrap_i[CASC]),
        .match_i(match_i[g]),
        .sync_clear_i(sync_any[g]),
        .count_o(count_o[g]),
        .clear_o(clear_o[g])
      );
    end
  endgenerate

  // ==========================================================
  // Checks
  property p_ctrl_reset;
    @(posedge clk_i) (rst_i || standby_i) |=> ctrl_reg[0] == 8'h00;
  endproperty
  a_ctrl_reset: assert property (p_ctrl_reset)
    else $error("control not cleared");

  property p_reserved;
    @(posedge clk_i) disable iff (rst_i) ctrl_reg[1][7] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit set");

  property p_no_clear;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[0][7:5] == 3'h0 || ctrl_reg[0][7:5] == 3'h4)
        |-> !clear_o[0];
  endproperty
  a_no_clear: assert property (p_no_clear)
    else $error("clear while disabled");

  property p_clear_a;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[3][7:5] == 3'h1 |-> clear_o[3] == match_i[3].match_a;
  endproperty
  a_clear_a: assert property (p_clear_a)
    else $error("clear A mismatch");

  property p_buffer;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[0][7:5] == 3'h5 && bufcd4_reg[0]) |-> !clear_o[0];
  endproperty
  a_buffer: assert property (p_buffer)
    else $error("buffer reg cleared counter");

  property p_sync;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[2][6:5] == 2'h3 && !sync_reg[2]) |-> !clear_o[2];
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync clear without enable");

  property p_div1;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[0][2:0] == 3'h0 |-> count_o[0];
  endproperty
  a_div1: assert property (p_div1)
    else $error("div1 not every cycle");

  property p_cascade;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[1][2:0] == 3'h7 |-> count_o[1] == wrap_i[2];
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascade mismatch");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
      (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack timing");

  // Reset and standby clear wide control 3 and narrow control 5 too
  property p_ctrl_reset_all;
    @(posedge clk_i) (rst_i || standby_i) |=>
      (ctrl_reg[3] == 8'h00 && ctrl_reg[5] == 8'h00);
  endproperty
  a_ctrl_reset_all: assert property (p_ctrl_reset_all)
    else $error("control 3 or 5 not cleared");

  // Reserved top bit stays low on narrow channels 2, 4 and 5
  property p_reserved_all;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl_reg[2][7] && !ctrl_reg[4][7] && !ctrl_reg[5][7];
  endproperty
  a_reserved_all: assert property (p_reserved_all)
    else $error("reserved bit set on narrow channel");

  // Code 101 follows match C when C is not a buffer
  property p_clear_c;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[0][7:5] == 3'h5 && !bufcd4_reg[0])
        |-> clear_o[0] == match_i[0].match_c;
  endproperty
  a_clear_c: assert property (p_clear_c)
    else $error("clear C mismatch");

  // Code 110 follows match D when D is not a buffer
  property p_clear_d;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[0][7:5] == 3'h6 && !bufcd4_reg[1])
        |-> clear_o[0] == match_i[0].match_d;
  endproperty
  a_clear_d: assert property (p_clear_d)
    else $error("clear D mismatch");

  // Sync codes follow any other enabled channel's clear
  property p_sync_clear;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[0][6:5] == 2'h3 && sync_reg[0])
        |-> clear_o[0] == |(sync_clear_i & sync_reg & 6'h3E);
  endproperty
  a_sync_clear: assert property (p_sync_clear)
    else $error("sync clear mismatch");

  // Narrow code 01 follows match A
  property p_narrow_a;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[1][6:5] == 2'h1 |-> clear_o[1] == match_i[1].match_a;
  endproperty
  a_narrow_a: assert property (p_narrow_a)
    else $error("narrow clear A mismatch");

  // Channel 4 code 7 passes channel 5 wrap strobes
  property p_cascade4;
    @(posedge clk_i) disable iff (rst_i)
      ctrl_reg[4][2:0] == 3'h7 |-> count_o[4] == wrap_i[5];
  endproperty
  a_cascade4: assert property (p_cascade4)
    else $error("cascade 4 mismatch");

  // Falling-edge mode on a pin counts only with the pin low
  property p_fall_only;
    @(posedge clk_i) disable iff (rst_i)
      (ctrl_reg[0][4:3] == 2'h1 && ctrl_reg[0][2] && count_o[0])
        |-> !ext_s2_reg[ctrl_reg[0][1:0]];
  endproperty
  a_fall_only: assert property (p_fall_only)
    else $error("fall count with pin high");
endmodule

// >>> hdl/ptccc_pkg.sv
// Purpose: Shared constants and types for the channel clock and clear control
// Assumes: Six channels, 8-bit control registers, classic Wishbone access
// Notes: Offsets are byte addresses on a 32-bit bus
package ptccc_pkg;
  // ==========================================================
  // Register map
  localparam int PTCCC_NCH = 6;
  localparam logic [7:0] PTCCC_CTRL_BASE = 8'h00;
  localparam logic [7:0] PTCCC_SYNC_OFF = 8'h18;
  localparam logic [7:0] PTCCC_BUFCD_OFF = 8'h1C;
  localparam logic [7:0] PTCCC_PHASE_OFF = 8'h20;
  localparam logic [7:0] PTCCC_CTRL_RST = 8'h00;
  localparam logic [5:0] PTCCC_SYNC_RST = 6'h00;
  // ==========================================================
  // Field positions
  localparam int PTCCC_CLR_HI = 7;
  localparam int PTCCC_CLR_LO = 5;
  localparam int PTCCC_EDGE_HI = 4;
  localparam int PTCCC_EDGE_LO = 3;
  localparam int PTCCC_PSC_HI = 2;
  localparam int PTCCC_PSC_LO = 0;
  localparam logic [7:0] PTCCC_NARROW_MASK = 8'h7F;
  // ==========================================================
  // Prescaler divisions as tap exponents of four
  localparam int PTCCC_PRE_BITS = 12;
  // ==========================================================
  // Clock source selection per channel
  typedef enum {
    PTCCC_SRC_INT, PTCCC_SRC_EXT, PTCCC_SRC_CASCADE
  } ptccc_src_e;
  // Per-channel event inputs grouped
  typedef struct packed {
    logic match_a;
    logic match_b;
    logic match_c;
    logic match_d;
  } ptccc_match_s;
endpackage

// >>> hdl/ptccc_chan.sv
// Purpose: One channel's clock source, edge and clear source decoder
// Assumes: Taps and pins already synchronised to clk_i
// Notes: Produces one-cycle count and clear strobes
`timescale 1ns/100ps
module ptccc_chan
  import ptccc_pkg::*;
#(
  parameter int CH = 0
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic [7:0] ctrl_i,
  input wire logic sync_en_i,
  input wire logic buf_c_i,
  input wire logic buf_d_i,
  input wire logic phase_i,
  // Sources
  input wire logic [6:0] tap_i,
  input wire logic [3:0] ext_i,
  input wire logic cascade_i,
  input wire ptccc_match_s match_i,
  input wire logic sync_clear_i,
  // Results
  output logic count_o,
  output logic clear_o
);
  logic [2:0] psc; // Prescale field
  logic [1:0] edge_sel; // Edge field
  logic [2:0] clr; // Clear field
  logic src_level; // Selected source level
  logic src_prev_reg; // Previous level
  logic edge_ok; // Edge honoured
  logic is_pulse; // Source is a strobe
  logic rise;
  logic fall;
  logic [2:0] clr_code;

  assign psc = ctrl_i[PTCCC_PSC_HI:PTCCC_PSC_LO];
  assign edge_sel = ctrl_i[PTCCC_EDGE_HI:PTCCC_EDGE_LO];
  assign clr = ctrl_i[PTCCC_CLR_HI:PTCCC_CLR_LO];

  // ==========================================================
  // Source multiplexer per channel
  always_comb
  begin
    src_level = 1'b0;
    is_pulse = 1'b0;
    case (CH)
      0:
      begin
        // Internal 1..64 then pins A..D
        if (psc[2]) src_level = ext_i[psc[1:0]];
        else src_level = tap_i[psc[1:0]];
        is_pulse = (psc == 3'h0);
      end
      1:
      begin
        case (psc)
          3'h4: src_level = ext_i[0];
          3'h5: src_level = ext_i[1];
          3'h6: src_level = tap_i[4];
          3'h7: src_level = cascade_i;
          default: src_level = tap_i[psc[1:0]];
        endcase
        is_pulse = (psc == 3'h0) || (psc == 3'h7);
      end
      2:
      begin
        case (psc)
          3'h4: src_level = ext_i[0];
          3'h5: src_level = ext_i[1];
          3'h6: src_level = ext_i[2];
          3'h7: src_level = tap_i[5];
          default: src_level = tap_i[psc[1:0]];
        endcase
        is_pulse = (psc == 3'h0);
      end
      3:
      begin
        case (psc)
          3'h4: src_level = ext_i[0];
          3'h5: src_level = tap_i[5];
          3'h6: src_level = tap_i[4];
          3'h7: src_level = tap_i[6];
          default: src_level = tap_i[psc[1:0]];
        endcase
        is_pulse = (psc == 3'h0);
      end
      4:
      begin
        case (psc)
          3'h4: src_level = ext_i[0];
          3'h5: src_level = ext_i[2];
          3'h6: src_level = tap_i[5];
          3'h7: src_level = cascade_i;
          default: src_level = tap_i[psc[1:0]];
        endcase
        is_pulse = (psc == 3'h0) || (psc == 3'h7);
      end
      default:
      begin
        case (psc)
          3'h4: src_level = ext_i[0];
          3'h5: src_level = ext_i[2];
          3'h6: src_level = tap_i[4];
          3'h7: src_level = ext_i[3];
          default: src_level = tap_i[psc[1:0]];
        endcase
        is_pulse = (psc == 3'h0);
      end
    endcase
  end

  // Previous source level for edge detection
  always_ff @(posedge clk_i)
  begin
    if (rst_i) src_prev_reg <= 1'b0;
    else src_prev_reg <= src_level;
  end

  assign rise = src_level & ~src_prev_reg;
  assign fall = ~src_level & src_prev_reg;
  // Phase counting overrides edge choice on narrow channels
  assign edge_ok = !(phase_i && (CH != 0) && (CH != 3));

  // ==========================================================
  // Count strobe: strobes pass straight, levels by edge
  always_comb
  begin
    if (is_pulse) count_o = src_level;
    else if (!edge_ok) count_o = rise;
    else if (edge_sel[1]) count_o = rise | fall;
    else if (edge_sel[0]) count_o = fall;
    else count_o = rise;
  end

  // ==========================================================
  // Clear source decode
  assign clr_code = ((CH == 0) || (CH == 3)) ? clr : {1'b0, clr[1:0]};
  always_comb
  begin
    case (clr_code)
      3'h1: clear_o = match_i.match_a;
      3'h2: clear_o = match_i.match_b;
      3'h5: clear_o = match_i.match_c & ~buf_c_i;
      3'h6: clear_o = match_i.match_d & ~buf_d_i;
      3'h3, 3'h7: clear_o = sync_clear_i & sync_en_i;
      default: clear_o = 1'b0;
    endcase
  end
endmodule

// >>> verification/ptccc_top_tb.sv
// Purpose: Self-checking bench for the channel clock and clear control
// Assumes: Registers at word offsets, ack one cycle after the request
// Notes: Each scenario task drives the block and judges what comes back
`timescale 1ns/100ps
module ptccc_top_tb
  import ptccc_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic standby_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [3:0] ext_clk_i = 4'h0;
  logic [5:0] wrap_i = 6'h00;
  ptccc_match_s [5:0] match_i = '0;
  logic [5:0] sync_clear_i = 6'h00;
  logic [5:0] count_o;
  logic [5:0] clear_o;
  int fails = 0;
  int checks_done = 0;
  int cnt [6];
  // 10 MHz system clock
  always #50 clk_i = ~clk_i;
  // Device under test
  ptccc_top u_ptccc_top (.clk_i(clk_i), .rst_i(rst_i), .standby_i(standby_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_clk_i(ext_clk_i),
    .wrap_i(wrap_i), .match_i(match_i), .sync_clear_i(sync_clear_i),
    .count_o(count_o), .clear_o(clear_o));
  // ==========================================================
  // Reporting
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  // ==========================================================
  // Wishbone classic cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                    input logic [7:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= {24'h000000, d};
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (ack_o === 1'b1)
        break;
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (i == 20)
    begin
      fails++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, 4'hF, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    wb(1'b0, a, 4'h0, 8'h00, q);
    chk(n, e, q);
  endtask
  // Event inputs set at an edge, outputs judged at the next negedge
  task automatic drive(input logic [3:0] m, input logic [5:0] sc,
                       input logic [5:0] w);
    @(posedge clk_i);
    match_i <= {6{m}};
    sync_clear_i <= sc;
    wrap_i <= w;
    @(negedge clk_i);
  endtask
  // Count strobes per channel over a window
  task automatic count_window(input int n);
    for (int c = 0; c < 6; c++)
      cnt[c] = 0;
    repeat (n)
    begin
      @(negedge clk_i);
      for (int c = 0; c < 6; c++)
        cnt[c] += (count_o[c] === 1'b1) ? 1 : 0;
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic sc_regs();
    logic [31:0] q;
    for (int c = 0; c < 6; c++)
      rd(8'(4 * c), 32'h0, "ctrl reset");
    for (int c = 0; c < 6; c++)
      wr(8'(4 * c), 8'hFF);
    for (int c = 0; c < 6; c++)
      rd(8'(4 * c), (c == 0 || c == 3) ? 32'hFF : 32'h7F, "ctrl rw");
    wb(1'b1, 8'h00, 4'h0, 8'h00, q);
    rd(8'h00, 32'hFF, "lane off write");
    rd(8'h40, 32'h0, "unmapped read");
    @(posedge clk_i);
    standby_i <= 1'b1;
    @(posedge clk_i);
    standby_i <= 1'b0;
    for (int c = 0; c < 6; c++)
      rd(8'(4 * c), 32'h0, "ctrl standby");
  endtask
  task automatic sc_clear();
    logic e;
    for (int code = 0; code < 7; code++)
    begin
      if (code == 3)
        continue;
      wr(8'h00, {3'(code), 5'h00});
      for (int j = 0; j < 4; j++)
      begin
        drive(4'b1000 >> j, 6'h00, 6'h00);
        e = (code == 1 && j == 0) || (code == 2 && j == 1) ||
            (code == 5 && j == 2) || (code == 6 && j == 3);
        chk("clear src", {31'h0, e}, {26'h0, clear_o});
      end
    end
    wr(8'h1C, 8'h01);
    wr(8'h00, 8'hA0);
    drive(4'b0010, 6'h00, 6'h00);
    chk("clear buffered", 32'h0, {26'h0, clear_o});
    wr(8'h1C, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'hA0);
    drive(4'b1000, 6'h00, 6'h00);
    chk("clear narrow", 32'h2, {26'h0, clear_o});
    wr(8'h04, 8'h00);
    wr(8'h0C, 8'h20);
    drive(4'b1000, 6'h00, 6'h00);
    chk("clear ch3 a", 32'h8, {26'h0, clear_o});
    wr(8'h0C, 8'h00);
    drive(4'h0, 6'h00, 6'h00);
  endtask
  task automatic sc_sync();
    wr(8'h18, 8'h03);
    wr(8'h00, 8'h60);
    wr(8'h04, 8'h60);
    wr(8'h08, 8'h60);
    drive(4'h0, 6'h03, 6'h00);
    chk("sync pair", 32'h3, {26'h0, clear_o});
    wr(8'h00, 8'hE0);
    drive(4'h0, 6'h04, 6'h00);
    chk("sync disabled src", 32'h0, {26'h0, clear_o});
    drive(4'h0, 6'h02, 6'h00);
    chk("sync code 7", 32'h1, {26'h0, clear_o});
    wr(8'h18, 8'h01);
    drive(4'h0, 6'h02, 6'h00);
    chk("sync off", 32'h0, {26'h0, clear_o});
    drive(4'h0, 6'h00, 6'h00);
    wr(8'h18, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
  endtask
  task automatic sc_count();
    wr(8'h00, 8'h08);
    count_window(16);
    chk("div1", 32'd16, cnt[0]);
    wr(8'h04, 8'h0F);
    wr(8'h10, 8'h17);
    drive(4'h0, 6'h00, 6'h24);
    chk("cascade on", 32'h3, {count_o[4], count_o[1]});
    drive(4'h0, 6'h00, 6'h00);
    chk("cascade off", 32'h0, {count_o[4], count_o[1]});
    wr(8'h04, 8'h06);
    count_window(256);
    chk("div256 ch1", 32'd1, cnt[1]);
    wr(8'h00, 8'h01);
    wr(8'h0C, 8'h02);
    count_window(64);
    chk("div4 rise", 32'd16, cnt[0]);
    chk("div16 ch3", 32'd4, cnt[3]);
    wr(8'h00, 8'h11);
    count_window(64);
    chk("div4 both", 32'd32, cnt[0]);
    wr(8'h04, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h0C, 8'h00);
  endtask
  task automatic sc_ext();
    for (int j = 0; j < 4; j++)
      for (int e = 0; e < 3; e++)
      begin
        wr(8'h00, {3'h0, 2'(e), 1'b1, 2'(j)});
        @(posedge clk_i);
        ext_clk_i[j] <= 1'b1;
        count_window(8);
        chk("pin rise", {31'h0, e != 1}, cnt[0]);
        @(posedge clk_i);
        ext_clk_i[j] <= 1'b0;
        count_window(8);
        chk("pin fall", {31'h0, e != 0}, cnt[0]);
      end
    wr(8'h00, 8'h00);
    wr(8'h20, 8'h02);
    wr(8'h04, 8'h0C);
    ext_clk_i[0] <= 1'b1;
    count_window(8);
    chk("phase rise", 32'd1, cnt[1]);
    @(posedge clk_i);
    ext_clk_i[0] <= 1'b0;
    count_window(8);
    chk("phase fall", 32'd0, cnt[1]);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    sc_regs();
    sc_clear();
    sc_sync();
    sc_count();
    sc_ext();
    tally_and_finish();
  end
endmodule
